// ---- logic/rbl_top.sv ----
// Radio block loopback control top level
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module rbl_top #(
    parameter int unsigned BLK_PERIOD_NS = 20000000
) (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic [rbl_pkg::ADDR_W-1:0]    addr,
    input  wire logic [rbl_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output var  logic [rbl_pkg::DATA_W-1:0]    rdata,
    input  wire logic                          rx_valid,
    input  wire logic [2:0]                    rx_ts,
    input  wire logic [rbl_pkg::BLK_W-1:0]     rx_data,
    input  wire logic                          rx_psk,
    input  wire logic                          rx_hdr_ok,
    input  wire logic                          rx_ctrl,
    input  wire logic [1:0]                    rx_ptype,
    input  wire logic                          tbf_release,
    input  wire logic                          t3190_exp,
    output var  logic                          tx_valid,
    output var  logic [2:0]                    tx_ts,
    output var  logic [rbl_pkg::BLK_W-1:0]     tx_data,
    output var  logic                          tx_gmsk,
    output var  logic [1:0]                    tx_seg,
    output var  logic                          tx_trunc,
    output var  logic                          fwd_valid,
    output var  logic                          fwd_opt_oct,
    output var  logic                          ctrl_obey,
    output var  logic                          own_tx_en,
    output var  logic                          tbf_hold,
    output var  logic                          timers_off,
    output var  logic                          ul_discard,
    output var  logic                          idle_ret
);
    import rbl_pkg::*;
    localparam int unsigned BLK_CYC = BLK_PERIOD_NS / CLK_NS;

    logic       rst_s1;
    logic       rst_n;
    logic       tick;
    rbl_state_e state;
    logic       start_req;
    logic       gmsk_ul;
    logic       ms_en;
    logic [2:0] dl_ofs;
    logic [7:0] dl_mask;
    logic [7:0] ul_mask;
    logic [1:0] last_pt;
    logic [1:0] seg;
    logic       seg_run;
    logic       scan_on;
    logic [2:0] scan_ts;
    logic       active;
    logic       term;
    logic       pt_cmd;
    logic       cap_ok;
    logic [3:0] ul_k;
    logic [3:0] n_dl;
    logic [3:0] src;
    logic [3:0] rx_ord;
    logic       fire;

    rbl_buf_if buf_if ();

    // ==================================================================
    // Reset release synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    rbl_tick #(.CYC(BLK_CYC)) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    rbl_echo u_echo (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (buf_if.store)
    );

    // ==================================================================
    // Decode terms
    assign active = (state != RBL_IDLE);
    assign term   = active && (tbf_release || t3190_exp);
    assign pt_cmd = rx_valid && rx_hdr_ok && rx_ctrl;
    assign rx_ord = rbl_dl_ord(dl_mask, dl_ofs, rx_ts);
    assign n_dl   = rbl_ones_below(dl_mask, 3'h7) + {3'h0, dl_mask[7]};
    assign ul_k   = rbl_ones_below(ul_mask, scan_ts);

    // Source ordinal for the uplink slot under scan
    always_comb begin
        src = 4'h0;
        if (ms_en && n_dl > 4'h1) begin
            src = (ul_k > n_dl - 4'h1) ? n_dl - 4'h1 : ul_k;
        end
    end
    // Single downlink slot or no multi-slot: ordinal zero everywhere

    // Capture gate: sub-mode ON, slot in TBF, not in the first two periods of a GMSK spread
    assign cap_ok = rx_valid && (state == RBL_ON) && dl_mask[rx_ts]
                    && (rx_ord[3:1] == 3'h0) && (ms_en || rx_ord == 4'h0)
                    && !(seg_run && seg != SEG_LAST);
    assign buf_if.wr_en   = cap_ok && (ms_en || rx_ord == 4'h0);
    assign buf_if.wr_idx  = rx_ord[2:0];
    assign buf_if.wr_data = rx_data;
    assign buf_if.wr_psk  = rx_psk;
    assign buf_if.swap    = tick && !(seg_run && seg != SEG_LAST);
    assign buf_if.rd_idx  = src[2:0];
    assign buf_if.flush   = term;
    assign fire = scan_on && ul_mask[scan_ts] && (state == RBL_ON) && buf_if.rd_vld;

    // ==================================================================
    // Register write port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_req <= 1'b0;
            gmsk_ul   <= 1'b0;
            ms_en     <= 1'b0;
            dl_ofs    <= OFS_RST;
            dl_mask   <= MASK_RST;
            ul_mask   <= MASK_RST;
        end else begin
            start_req <= wr && (addr == REG_CTRL) && wdata[CTRL_START];
            if (wr && addr == REG_CTRL) begin
                gmsk_ul <= wdata[CTRL_GMSK];
                ms_en   <= wdata[CTRL_MS];
                dl_ofs  <= wdata[CTRL_OFS+:3];
            end
            if (wr && addr == REG_DL_MASK) begin
                dl_mask <= wdata[7:0];
            end
            if (wr && addr == REG_UL_MASK) begin
                ul_mask <= wdata[7:0];
            end
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                REG_CTRL:    rdata <= {25'h0, dl_ofs, 1'b0, ms_en, gmsk_ul, 1'b0};
                REG_DL_MASK: rdata <= {24'h0, dl_mask};
                REG_UL_MASK: rdata <= {24'h0, ul_mask};
                REG_STATUS:  rdata <= {25'h0, seg_run, seg, last_pt, state == RBL_ON, active};
                default:     rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // ==================================================================
    // Loopback sub-mode state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RBL_IDLE;
        end else begin
            case (state)
                RBL_IDLE: begin
                    if (start_req) begin
                        state <= RBL_ON;
                    end
                end
                RBL_ON: begin
                    if (term) begin
                        state <= RBL_IDLE;
                    end else if (pt_cmd && rbl_pt_off(rx_ptype)) begin
                        state <= RBL_OFF;
                    end
                end
                RBL_OFF: begin
                    if (term) begin
                        state <= RBL_IDLE;
                    end else if (pt_cmd && !rbl_pt_off(rx_ptype)) begin
                        state <= RBL_ON;
                    end
                end
                default: state <= RBL_IDLE;
            endcase
        end
    end
    // Same-mode commands fall through both arms unchanged

    // Last payload type taken as a command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pt <= PT_ON_NOOPT;
        end else if (active && pt_cmd) begin
            last_pt <= rx_ptype;
        end
    end

    // ==================================================================
    // GMSK spread of 8PSK blocks over three periods
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg     <= 2'h0;
            seg_run <= 1'b0;
        end else if (term) begin
            seg     <= 2'h0;
            seg_run <= 1'b0;
        end else if (tick) begin
            if (seg_run && seg != SEG_LAST) begin
                seg <= seg + 2'h1;
            end else begin
                seg     <= 2'h0;
                seg_run <= gmsk_ul && buf_if.cap_psk;
            end
        end
    end

    // Uplink slot scan after each period tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_on <= 1'b0;
            scan_ts <= 3'h0;
        end else if (tick) begin
            scan_on <= 1'b1;
            scan_ts <= 3'h0;
        end else if (scan_on) begin
            scan_ts <= scan_ts + 3'h1;
            scan_on <= (scan_ts != 3'h7);
        end
    end

    // Echo transmit request, USF and TFI not consulted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_ts    <= 3'h0;
            tx_data  <= '0;
            tx_gmsk  <= 1'b0;
            tx_seg   <= 2'h0;
            tx_trunc <= 1'b0;
        end else begin
            tx_valid <= fire && !term;
            tx_ts    <= scan_ts;
            tx_gmsk  <= gmsk_ul;
            tx_seg   <= seg_run ? seg : 2'h0;
            tx_trunc <= fire && gmsk_ul && buf_if.rd_psk;
            if (gmsk_ul && buf_if.rd_psk) begin
                tx_data <= {buf_if.rd_data[BLK_W-1:TRUNC_BITS], {TRUNC_BITS{1'b0}}};
            end else begin
                tx_data <= buf_if.rd_data;
            end
        end
    end

    // ==================================================================
    // Decoded path, link control and termination outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_valid   <= 1'b0;
            fwd_opt_oct <= 1'b0;
            ctrl_obey   <= 1'b0;
            own_tx_en   <= 1'b1;
            tbf_hold    <= 1'b0;
            timers_off  <= 1'b0;
            ul_discard  <= 1'b0;
            idle_ret    <= 1'b0;
        end else begin
            fwd_valid   <= rx_valid && rx_hdr_ok;
            fwd_opt_oct <= active && (last_pt == PT_ON_OPT);
            ctrl_obey   <= pt_cmd;
            own_tx_en   <= (state != RBL_ON) || term;
            tbf_hold    <= active && !term;
            timers_off  <= active && !term;
            ul_discard  <= term;
            idle_ret    <= term;
        end
    end

    // ==================================================================
    // Checks
    a_start_on: assert property (@(posedge clk) disable iff (!rst_n)
        (state == RBL_IDLE && start_req) |=> state == RBL_ON)
        else $error("start did not enter sub-mode ON");
    a_pt_off: assert property (@(posedge clk) disable iff (!rst_n)
        (state == RBL_ON && pt_cmd && rx_ptype[0] && !term) |=> state == RBL_OFF)
        else $error("off code did not leave sub-mode ON");
    a_pt_on: assert property (@(posedge clk) disable iff (!rst_n)
        (state == RBL_ON && pt_cmd && !rx_ptype[0] && !term) |=> state == RBL_ON)
        else $error("on command in sub-mode ON changed state");
    a_hdr_fail: assert property (@(posedge clk) disable iff (!rst_n)
        (active && !term && !pt_cmd && !start_req) |=> $stable(state))
        else $error("sub-mode moved without a good control header");
    a_term_idle: assert property (@(posedge clk) disable iff (!rst_n)
        term |=> (state == RBL_IDLE && idle_ret && ul_discard) ##1 !tx_valid)
        else $error("termination did not return to idle");
    a_hold_tbf: assert property (@(posedge clk) disable iff (!rst_n)
        (active && !term) |=> (tbf_hold && timers_off))
        else $error("TBF hold or timer disable missing in loopback");
    a_no_echo: assert property (@(posedge clk) disable iff (!rst_n)
        (state != RBL_ON) |=> !tx_valid)
        else $error("echo sent outside sub-mode ON");
    a_own_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (state == RBL_ON && !term) |=> !own_tx_en)
        else $error("own traffic enabled in sub-mode ON");
    a_trunc_gmsk: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_valid && tx_trunc) |-> (tx_gmsk && tx_data[TRUNC_BITS-1:0] == '0))
        else $error("8PSK echo tail not dropped");
    a_fwd_hdr: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_valid && rx_hdr_ok) |=> fwd_valid)
        else $error("good header not forwarded");
    a_seg_spread: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && seg_run && seg == 2'h0 && !term) |=> seg == 2'h1)
        else $error("8PSK spread did not advance");

    c_on_off: cover property (@(posedge clk) disable iff (!rst_n)
        state == RBL_ON ##1 state == RBL_OFF);
    c_echo: cover property (@(posedge clk) disable iff (!rst_n) tx_valid);
    c_term: cover property (@(posedge clk) disable iff (!rst_n) idle_ret);
    c_spread: cover property (@(posedge clk) disable iff (!rst_n)
        tx_valid && tx_seg == SEG_LAST);
endmodule : rbl_top
`default_nettype wire

// ---- logic/rbl_pkg.sv ----
// Constants, codes and helper functions for radio block loopback control
// ==========================================================================
package rbl_pkg;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned BLK_W      = 64;
    localparam int unsigned TRUNC_BITS = 16;
    localparam int unsigned CNT_W      = 24;
    localparam int unsigned CLK_NS     = 10;
    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] REG_DL_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] REG_UL_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 4'hc;
    // Control fields and reset values
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_GMSK  = 1;
    localparam int unsigned CTRL_MS    = 2;
    localparam int unsigned CTRL_OFS   = 4;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [2:0]  OFS_RST    = 3'h0;
    // Payload type codes and last GMSK spread segment
    localparam logic [1:0] PT_ON_NOOPT  = 2'h0;
    localparam logic [1:0] PT_OFF_NOOPT = 2'h1;
    localparam logic [1:0] PT_ON_OPT    = 2'h2;
    localparam logic [1:0] PT_OFF_RSV   = 2'h3;
    localparam logic [1:0] SEG_LAST     = 2'h2;

    typedef enum logic [1:0] {RBL_IDLE, RBL_ON, RBL_OFF} rbl_state_e;

    // Sub-mode commanded by a payload type code
    function automatic logic rbl_pt_off(input logic [1:0] pt);
        return (pt == PT_OFF_NOOPT) || (pt == PT_OFF_RSV);
    endfunction : rbl_pt_off

    // Number of set mask bits below slot s
    function automatic logic [3:0] rbl_ones_below(input logic [7:0] m, input logic [2:0] s);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(s) && m[i]) begin
                n = n + 4'h1;
            end
        end
        return n;
    endfunction : rbl_ones_below

    // Ordinal of slot s counted from offset, wrapping through slot 7
    function automatic logic [3:0] rbl_dl_ord(input logic [7:0] m, input logic [2:0] ofs,
                                              input logic [2:0] s);
        logic [3:0] n;
        logic       hit;
        logic [2:0] j;
        n   = 4'h0;
        hit = 1'b0;
        j   = 3'h0;
        for (int i = 0; i < 8; i++) begin
            j = 3'(ofs + 3'(i));
            if (j == s) begin
                hit = 1'b1;
            end
            if (!hit && m[j]) begin
                n = n + 4'h1;
            end
        end
        return n;
    endfunction : rbl_dl_ord
endpackage : rbl_pkg

// ---- logic/rbl_buf_if.sv ----
// Interface between loopback control and echo block store
`timescale 1ns/100ps
`default_nettype none
interface rbl_buf_if;
    import rbl_pkg::*;
    logic             wr_en;
    logic [2:0]       wr_idx;
    logic [BLK_W-1:0] wr_data;
    logic             wr_psk;
    logic             swap;
    logic             cap_psk;
    logic [2:0]       rd_idx;
    logic [BLK_W-1:0] rd_data;
    logic             rd_vld;
    logic             rd_psk;
    logic             flush;
    modport store (input wr_en, wr_idx, wr_data, wr_psk, swap, rd_idx, flush,
                   output cap_psk, rd_data, rd_vld, rd_psk);
    modport ctrl  (output wr_en, wr_idx, wr_data, wr_psk, swap, rd_idx, flush,
                   input cap_psk, rd_data, rd_vld, rd_psk);
endinterface : rbl_buf_if
`default_nettype wire

// ---- logic/rbl_tick.sv ----
// Block period divider producing a one-cycle tick
`timescale 1ns/100ps
`default_nettype none
module rbl_tick #(
    parameter int unsigned CYC = 2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output var  logic tick
);
    import rbl_pkg::*;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYC - 1);
    logic [CNT_W-1:0] cnt;

    // ==================================================================
    // Free running period counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt == LAST);
            cnt  <= (cnt == LAST) ? '0 : cnt + CNT_W'(1);
        end
    end
endmodule : rbl_tick
`default_nettype wire

// ---- logic/rbl_echo.sv ----
// Two-bank store of raw received blocks for uplink echo
`timescale 1ns/100ps
`default_nettype none
module rbl_echo (
    input  wire logic clk,
    input  wire logic rst_n,
    rbl_buf_if.store  bus
);
    import rbl_pkg::*;
    logic [BLK_W-1:0] cap_mem [8];
    logic [BLK_W-1:0] out_mem [8];
    logic [7:0]       cap_vld;
    logic [7:0]       cap_psk;
    logic [7:0]       out_vld;
    logic [7:0]       out_psk;

    // ==================================================================
    // Capture bank, cleared at each period swap; a write beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_vld <= 8'h00;
            cap_psk <= 8'h00;
        end else begin
            if (bus.swap || bus.flush) begin
                cap_vld <= 8'h00;
            end
            if (bus.wr_en) begin
                cap_vld[bus.wr_idx] <= 1'b1;
                cap_psk[bus.wr_idx] <= bus.wr_psk;
            end
        end
    end

    // Block payload storage
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            cap_mem[bus.wr_idx] <= bus.wr_data;
        end
        if (bus.swap) begin
            out_mem <= cap_mem;
        end
    end

    // Output bank, loaded once per period outside a GMSK spread for the next period's echo
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_vld <= 8'h00;
            out_psk <= 8'h00;
        end else if (bus.flush) begin
            out_vld <= 8'h00;
        end else if (bus.swap) begin
            out_vld <= cap_vld;
            out_psk <= cap_psk;
        end
    end

    assign bus.cap_psk = |(cap_vld & cap_psk);
    assign bus.rd_data = out_mem[bus.rd_idx];
    assign bus.rd_vld  = out_vld[bus.rd_idx];
    assign bus.rd_psk  = out_psk[bus.rd_idx];
endmodule : rbl_echo
`default_nettype wire

// ---- sim/rbl_sim.sv ----
// Test simulator model driving downlink radio blocks
`timescale 1ns/100ps
`default_nettype none
module rbl_sim (
    input  wire logic        clk,
    input  wire logic        kick,
    input  wire logic [2:0]  ts,
    input  wire logic [63:0] data,
    input  wire logic [3:0]  kind,
    output var  logic        rx_valid,
    output var  logic [2:0]  rx_ts,
    output var  logic [63:0] rx_data,
    output var  logic        rx_psk,
    output var  logic        rx_hdr_ok,
    output var  logic        rx_ctrl,
    output var  logic [1:0]  rx_ptype
);
    // ======================================================================
    // Block source
    initial begin
        {rx_valid, rx_ts, rx_data, rx_psk, rx_hdr_ok, rx_ctrl, rx_ptype} = '0;
    end
    // Echo stealing bits are never read back by this model
    // One block per kick; fields flip between blocks so stale values never match
    always @(posedge clk) begin
        rx_valid  <= kick;
        rx_ts     <= kick ? ts : ~rx_ts;
        rx_data   <= kick ? data : ~rx_data;
        rx_hdr_ok <= kick ? kind[3] : ~rx_hdr_ok;
        rx_ctrl   <= kick ? kind[2] : ~rx_ctrl;
        rx_ptype  <= kick ? kind[1:0] : ~rx_ptype;
        rx_psk    <= 1'b0; // GMSK downlink only, so no dummy padding due
    end
endmodule : rbl_sim
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for radio block loopback control
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rbl_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, kick = 1'b0;
    logic tbf_release = 1'b0, t3190_exp = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0, v, rdata;
    logic [2:0] ts = 3'h0, rx_ts, tx_ts;
    logic [63:0] data = 64'h0, rx_data, tx_data;
    logic [3:0] kind = 4'h0;
    logic [1:0] rx_ptype, tx_seg;
    logic rx_valid, rx_psk, rx_hdr_ok, rx_ctrl, tx_valid, tx_gmsk, tx_trunc, fwd_valid;
    logic fwd_opt_oct, ctrl_obey, own_tx_en, tbf_hold, timers_off, ul_discard, idle_ret;
    int failures = 0, tests_run = 0, cycles = 0;
    logic [1:0] pt_row [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h1, 2'h0};
    logic       on_row [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    // ======================================================================
    // Clock, parts and timeout
    always #5 clk = ~clk;
    rbl_top #(.BLK_PERIOD_NS(200)) uut (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
        .rx_valid, .rx_ts, .rx_data, .rx_psk, .rx_hdr_ok, .rx_ctrl, .rx_ptype, .tbf_release,
        .t3190_exp, .tx_valid, .tx_ts, .tx_data, .tx_gmsk, .tx_seg, .tx_trunc, .fwd_valid,
        .fwd_opt_oct, .ctrl_obey, .own_tx_en, .tbf_hold, .timers_off, .ul_discard, .idle_ret);
    rbl_sim sim (.clk, .kick, .ts, .data, .kind, .rx_valid, .rx_ts, .rx_data, .rx_psk,
        .rx_hdr_ok, .rx_ctrl, .rx_ptype);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    // ======================================================================
    // Tasks
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rreg
    // Kind is header ok, control, payload type
    task automatic send(input logic [63:0] d, input logic [3:0] k);
        @(posedge clk);
        data <= d;
        kind <= k;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        @(posedge clk);
        #1;
        chk("ctrl_obey", ctrl_obey, k[3] & k[2]);
        chk("fwd_valid", fwd_valid, k[3]);
    endtask : send
    // Count echoes over 45 cycles, just over two block periods
    task automatic watch(input logic [63:0] e, input int n_exp);
        int n;
        n = 0;
        repeat (45) begin
            @(posedge clk);
            #1;
            if (tx_valid === 1'b1) begin
                n++;
                chk("tx_data", tx_data, e);
                chk("tx_ts", tx_ts, 3'h0);
            end
        end
        chk("tx_count", 64'(n), 64'(n_exp));
        $display("test watch done");
    endtask : watch
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // ======================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("own_tx_en", own_tx_en, 1'b1);
        chk("tbf_hold", tbf_hold, 1'b0);
        rreg(REG_STATUS, v);
        chk("status", v, 32'h0);
        wreg(REG_DL_MASK, 32'h1);
        wreg(REG_UL_MASK, 32'h1);
        rreg(4'h2, v);
        chk("unmapped", v, 32'h0);
        wreg(REG_CTRL, 32'h1);
        rreg(REG_STATUS, v);
        chk("start_on", v[1:0], 2'h3);
        chk("tbf_hold", {tbf_hold, timers_off}, 2'h3);
        $display("test reset_start done");
        for (int i = 0; i < 6; i++) begin
            send(64'h0, {2'b11, pt_row[i]});
            rreg(REG_STATUS, v);
            chk("sub_mode", v[1:0], {on_row[i], 1'b1});
            chk("own_tx_en", own_tx_en, !on_row[i]);
            chk("fwd_opt_oct", fwd_opt_oct, pt_row[i] == 2'h2);
        end
        $display("test sub_mode rows done");
        send(64'h0, 4'b0101);
        rreg(REG_STATUS, v);
        chk("bad_header", v[1:0], 2'h3);
        // Let echoes of earlier captured blocks drain first
        repeat (30) @(posedge clk);
        send(64'h0123456789abcdef, 4'b1000);
        watch(64'h0123456789abcdef, 1);
        send(64'h0, 4'b1101);
        send(64'h55aa55aa55aa55aa, 4'b1000);
        watch(64'h0, 0);
        for (int j = 0; j < 2; j++) begin
            if (j == 1) begin
                wreg(REG_CTRL, 32'h1);
            end
            @(posedge clk);
            tbf_release <= (j == 0);
            t3190_exp   <= (j == 1);
            @(posedge clk);
            tbf_release <= 1'b0;
            t3190_exp   <= 1'b0;
            #1;
            chk("end_pulses", {idle_ret, ul_discard}, 2'h3);
            rreg(REG_STATUS, v);
            chk("end_status", {v[0], tbf_hold, timers_off}, 3'h0);
        end
        send(64'h0f0f0f0f0f0f0f0f, 4'b1000);
        watch(64'h0, 0);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
